// ===== hw/rta_alarm_flags.sv
// Alarm compare and event-flag section of the real-time clock: century
// register, five alarm registers, sticky event flags with write-one-to-clear,
// interrupt enables, event choice and the interrupt output.
// Assumes an 8-bit register port driven on sys_clk and BCD time values plus
// the update-granted pulse from the time counters on the same clock.
`timescale 1ns/1ps

// Functional notes
// - Century register accepts only BCD 19 or 20; other writes are ignored.
// - Second alarm: BCD compare value in low bits, enable in bit 7.
// - Minute alarm: BCD compare value in low bits, enable in bit 7.
// - Hour alarm: BCD compare value in low bits, enable in bit 7.
// - Date alarm: BCD compare value in low bits, enable in bit 7.
// - Month alarm: BCD compare value in low bits, enable in bit 7.
// - A field takes part in the match only while its enable is 1.
// - Flag 0 reads 1 once the time registers may be written.
// - Flag 1 sets on an alarm match and holds until cleared.
// - Flag 2 sets on any second event and holds until cleared.
// - Flag 3 sets on the chosen time event and holds until cleared.
// - Flag 4 sets on the chosen calendar event and holds until cleared.
// - Interrupt is high while any enabled flag is set.
// - Writing 1 to a clear bit drops that flag; 0 leaves it.
// - Clearing the only enabled active flag drops the interrupt.
// - One interrupt enable bit per flag, bits 0 to 4.
// - Time choice: 00 minute, 01 hour, 10 midnight, 11 noon.
// - Calendar choice: 00 Sunday, 01 first of month, 10 January 1st, 11 none.
module rta_alarm_flags
  import rta_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] busAddr,
  input wire logic busWrEn,
  input wire logic busRdEn,
  input wire logic [DATA_W-1:0] busWrData,
  output logic [DATA_W-1:0] busRdData,
  input wire logic [7:0] curSec,
  input wire logic [7:0] curMin,
  input wire logic [7:0] curHour,
  input wire logic [7:0] curDay,
  input wire logic [7:0] curDate,
  input wire logic [7:0] curMonth,
  input wire logic updateGranted,
  output logic irq
);

  logic [7:0] centuryValue_q;
  logic [7:0] alarm_q [NUM_ALARMS];
  logic [NUM_FLAGS-1:0] eventFlags_q;
  logic [NUM_FLAGS-1:0] eventFlags_d;
  logic [NUM_FLAGS-1:0] interruptEnables_q;
  rta_time_choice_e timeEventChoice_q;
  rta_cal_choice_e calendarEventChoice_q;
  logic [DATA_W-1:0] busRdData_q;
  logic [DATA_W-1:0] readMux;
  logic irq_q;
  logic matchPrev_q;
  logic allMatch;
  logic alarmEvent;
  logic secondEvent;
  logic timeEvent;
  logic calendarEvent;
  logic [NUM_FLAGS-1:0] setVec;
  logic [NUM_FLAGS-1:0] clrVec;
  logic clearWrite;

  rta_alarm_match u_match (
    .sys_clk(sys_clk),
    .reset(reset),
    .secondAlarm(alarm_q[ALM_SEC]),
    .minuteAlarm(alarm_q[ALM_MIN]),
    .hourAlarm(alarm_q[ALM_HOUR]),
    .dateAlarm(alarm_q[ALM_DATE]),
    .monthAlarm(alarm_q[ALM_MONTH]),
    .curSec(curSec),
    .curMin(curMin),
    .curHour(curHour),
    .curDate(curDate),
    .curMonth(curMonth),
    .allMatch(allMatch)
  );

  rta_event_detect u_events (
    .sys_clk(sys_clk),
    .reset(reset),
    .curSec(curSec),
    .curMin(curMin),
    .curHour(curHour),
    .curDay(curDay),
    .curDate(curDate),
    .curMonth(curMonth),
    .timeEventChoice(timeEventChoice_q),
    .calendarEventChoice(calendarEventChoice_q),
    .secondEvent(secondEvent),
    .timeEvent(timeEvent),
    .calendarEvent(calendarEvent)
  );

  // Century register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      centuryValue_q <= CENTURY_RST;
    end else if (busWrEn && busAddr == OFF_CENTURY &&
                 (busWrData == CENTURY_LOW || busWrData == CENTURY_HIGH)) begin
      centuryValue_q <= busWrData;
    end
  end

  // Alarm registers, slot index is the offset above the seconds alarm
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int k = 0; k < NUM_ALARMS; k++) begin
        alarm_q[k] <= ALARM_RST;
      end
    end else if (busWrEn && busAddr >= OFF_SEC_ALARM && busAddr <= OFF_DATE_ALARM) begin
      alarm_q[3'(busAddr - OFF_SEC_ALARM)] <= busWrData;
    end
  end

  // Interrupt enables and event choice
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      interruptEnables_q <= IRQ_ENABLES_RST;
    end else if (busWrEn && busAddr == OFF_INTERRUPT_ENABLES) begin
      interruptEnables_q <= busWrData[NUM_FLAGS-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      timeEventChoice_q <= rta_time_choice_e'(CHOICE_RST);
      calendarEventChoice_q <= rta_cal_choice_e'(CHOICE_RST);
    end else if (busWrEn && busAddr == OFF_EVENT_CHOICE) begin
      timeEventChoice_q <= rta_time_choice_e'(busWrData[TIME_CHOICE_LSB +: 2]);
      calendarEventChoice_q <= rta_cal_choice_e'(busWrData[CAL_CHOICE_LSB +: 2]);
    end
  end

  // Alarm fires on the edge where the match begins, so one match window
  // gives one flag set even if software clears it inside the window.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      matchPrev_q <= 1'b0;
    end else begin
      matchPrev_q <= allMatch;
    end
  end

  assign alarmEvent = allMatch && !matchPrev_q;

  assign setVec[FLAG_UPDATE_GRANTED] = updateGranted;
  assign setVec[FLAG_ALARM] = alarmEvent;
  assign setVec[FLAG_SECOND] = secondEvent;
  assign setVec[FLAG_TIME_EVENT] = timeEvent;
  assign setVec[FLAG_CALENDAR_EVENT] = calendarEvent;

  assign clearWrite = busWrEn && (busAddr == OFF_EVENT_FLAG_CLEAR);
  assign clrVec = clearWrite ? busWrData[NUM_FLAGS-1:0] : '0;

  // Set is ORed after the clear so a coincident event survives
  assign eventFlags_d = (eventFlags_q & ~clrVec) | setVec;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      eventFlags_q <= FLAGS_RST;
    end else begin
      eventFlags_q <= eventFlags_d;
    end
  end

  // Interrupt follows the flag and enable registers one cycle later
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(eventFlags_q & interruptEnables_q);
    end
  end

  // Read path; unmapped and write-only offsets read as zero
  always_comb begin
    readMux = '0;
    case (busAddr)
      OFF_CENTURY: readMux = centuryValue_q;
      OFF_SEC_ALARM: readMux = alarm_q[ALM_SEC];
      OFF_MIN_ALARM: readMux = alarm_q[ALM_MIN];
      OFF_HOUR_ALARM: readMux = alarm_q[ALM_HOUR];
      OFF_MONTH_ALARM: readMux = alarm_q[ALM_MONTH];
      OFF_DATE_ALARM: readMux = alarm_q[ALM_DATE];
      OFF_EVENT_FLAGS: readMux = {3'h0, eventFlags_q};
      OFF_INTERRUPT_ENABLES: readMux = {3'h0, interruptEnables_q};
      OFF_EVENT_CHOICE: readMux = {2'h0, calendarEventChoice_q, 2'h0, timeEventChoice_q};
      default: readMux = '0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busRdData_q <= '0;
    end else if (busRdEn) begin
      busRdData_q <= readMux;
    end
  end

  assign busRdData = busRdData_q;
  assign irq = irq_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_matchBegins;
    !allMatch ##1 allMatch;
  endsequence

  sequence s_secClearAlone;
    clearWrite && busWrData[FLAG_SECOND] && !secondEvent;
  endsequence

  chk_century_legal: assert property (
    centuryValue_q == CENTURY_RST || centuryValue_q == CENTURY_LOW
      || centuryValue_q == CENTURY_HIGH)
    else $error("century holds an illegal value");

  chk_sec_alarm_store: assert property (
    (busWrEn && busAddr == OFF_SEC_ALARM) |=> alarm_q[ALM_SEC] == $past(busWrData))
    else $error("second alarm write not stored");

  chk_month_alarm_store: assert property (
    (busWrEn && busAddr == OFF_MONTH_ALARM) |=> alarm_q[ALM_MONTH] == $past(busWrData))
    else $error("month alarm write not stored");

  chk_alarm_flag_set: assert property (
    s_matchBegins |=> eventFlags_q[FLAG_ALARM])
    else $error("alarm flag not set on match");

  chk_clear_drops: assert property (
    s_secClearAlone |=> !eventFlags_q[FLAG_SECOND])
    else $error("second flag not cleared");

  chk_set_wins: assert property (
    (clearWrite && busWrData[FLAG_SECOND] && secondEvent) |=> eventFlags_q[FLAG_SECOND])
    else $error("second event lost to coincident clear");

  chk_time_sticky: assert property (
    (eventFlags_q[FLAG_TIME_EVENT] && !(clearWrite && busWrData[FLAG_TIME_EVENT]))
      |=> eventFlags_q[FLAG_TIME_EVENT])
    else $error("time event flag dropped without clear");

  chk_irq_raise: assert property (
    (eventFlags_q[FLAG_UPDATE_GRANTED] && interruptEnables_q[FLAG_UPDATE_GRANTED])
      |=> irq)
    else $error("interrupt missing for enabled flag");

  chk_irq_drop: assert property (
    ((eventFlags_q & interruptEnables_q) == '0) [*2] |-> !irq)
    else $error("interrupt high with no enabled flag");

  chk_flags_read: assert property (
    (busRdEn && busAddr == OFF_EVENT_FLAGS) |=> busRdData == {3'h0, $past(eventFlags_q)})
    else $error("event flag readback mismatch");

  chk_min_alarm_store: assert property (
    (busWrEn && busAddr == OFF_MIN_ALARM) |=> alarm_q[ALM_MIN] == $past(busWrData))
    else $error("minute alarm write not stored");

  chk_hour_alarm_store: assert property (
    (busWrEn && busAddr == OFF_HOUR_ALARM) |=> alarm_q[ALM_HOUR] == $past(busWrData))
    else $error("hour alarm write not stored");

  chk_date_alarm_store: assert property (
    (busWrEn && busAddr == OFF_DATE_ALARM) |=> alarm_q[ALM_DATE] == $past(busWrData))
    else $error("date alarm write not stored");

  chk_century_reject: assert property (
    (busWrEn && busAddr == OFF_CENTURY && busWrData != CENTURY_LOW
      && busWrData != CENTURY_HIGH) |=> $stable(centuryValue_q))
    else $error("illegal century write took effect");

  chk_update_set: assert property (
    updateGranted |=> eventFlags_q[FLAG_UPDATE_GRANTED])
    else $error("update granted flag not set");

  chk_update_sticky: assert property (
    (eventFlags_q[FLAG_UPDATE_GRANTED] && !(clearWrite && busWrData[FLAG_UPDATE_GRANTED]))
      |=> eventFlags_q[FLAG_UPDATE_GRANTED])
    else $error("update granted flag dropped without clear");

  chk_second_set: assert property (
    secondEvent |=> eventFlags_q[FLAG_SECOND])
    else $error("second flag not set on second event");

  chk_second_sticky: assert property (
    (eventFlags_q[FLAG_SECOND] && !(clearWrite && busWrData[FLAG_SECOND]))
      |=> eventFlags_q[FLAG_SECOND])
    else $error("second flag dropped without clear");

  chk_time_set: assert property (
    timeEvent |=> eventFlags_q[FLAG_TIME_EVENT])
    else $error("time event flag not set");

  chk_cal_set: assert property (
    calendarEvent |=> eventFlags_q[FLAG_CALENDAR_EVENT])
    else $error("calendar event flag not set");

  chk_cal_sticky: assert property (
    (eventFlags_q[FLAG_CALENDAR_EVENT] && !(clearWrite && busWrData[FLAG_CALENDAR_EVENT]))
      |=> eventFlags_q[FLAG_CALENDAR_EVENT])
    else $error("calendar event flag dropped without clear");

  chk_alarm_sticky: assert property (
    (eventFlags_q[FLAG_ALARM] && !(clearWrite && busWrData[FLAG_ALARM]))
      |=> eventFlags_q[FLAG_ALARM])
    else $error("alarm flag dropped without clear");

  chk_cal_clear_drops: assert property (
    (clearWrite && busWrData[FLAG_CALENDAR_EVENT] && !calendarEvent)
      |=> !eventFlags_q[FLAG_CALENDAR_EVENT])
    else $error("calendar event flag not cleared");

  chk_irq_masked: assert property (
    (interruptEnables_q == '0) |=> !irq)
    else $error("interrupt high with every enable off");

  chk_irq_second: assert property (
    (eventFlags_q[FLAG_SECOND] && interruptEnables_q[FLAG_SECOND]) |=> irq)
    else $error("interrupt missing for enabled second flag");

  chk_enables_store: assert property (
    (busWrEn && busAddr == OFF_INTERRUPT_ENABLES)
      |=> interruptEnables_q == $past(busWrData[NUM_FLAGS-1:0]))
    else $error("interrupt enable write not stored");

  chk_choice_store: assert property (
    (busWrEn && busAddr == OFF_EVENT_CHOICE)
      |=> timeEventChoice_q == $past(busWrData[TIME_CHOICE_LSB +: 2])
      && calendarEventChoice_q == $past(busWrData[CAL_CHOICE_LSB +: 2]))
    else $error("event choice write not stored");

  // Clear that leaves no enabled flag standing; irq is registered, so it drops two edges on
  sequence s_lastSourceCleared;
    clearWrite && ((eventFlags_d & interruptEnables_q) == '0);
  endsequence

  chk_irq_source_cleared: assert property (
    s_lastSourceCleared |=> ##1 !irq)
    else $error("interrupt held after its last source cleared");

endmodule : rta_alarm_flags

// ===== pkg/rta_pkg.sv
// Constants shared by the alarm and event-flag block of the real-time clock.
// Assumes an 8-bit register bus and BCD time values from the time counters.
package rta_pkg;

  localparam int DATA_W = 8;
  localparam int NUM_ALARMS = 5;
  localparam int NUM_FLAGS = 5;
  localparam int NUM_TIME_FIELDS = 6;

  // Register offsets
  localparam logic [7:0] OFF_CENTURY = 8'h0c;
  localparam logic [7:0] OFF_SEC_ALARM = 8'h10;
  localparam logic [7:0] OFF_MIN_ALARM = 8'h11;
  localparam logic [7:0] OFF_HOUR_ALARM = 8'h12;
  localparam logic [7:0] OFF_MONTH_ALARM = 8'h13;
  localparam logic [7:0] OFF_DATE_ALARM = 8'h14;
  localparam logic [7:0] OFF_EVENT_FLAGS = 8'h18;
  localparam logic [7:0] OFF_EVENT_FLAG_CLEAR = 8'h1c;
  localparam logic [7:0] OFF_INTERRUPT_ENABLES = 8'h20;
  localparam logic [7:0] OFF_EVENT_CHOICE = 8'h24;

  // Alarm slot indices (offset minus OFF_SEC_ALARM)
  localparam int ALM_SEC = 0;
  localparam int ALM_MIN = 1;
  localparam int ALM_HOUR = 2;
  localparam int ALM_MONTH = 3;
  localparam int ALM_DATE = 4;

  // Field positions
  localparam int ALARM_ENABLE_BIT = 7;
  localparam int FLAG_UPDATE_GRANTED = 0;
  localparam int FLAG_ALARM = 1;
  localparam int FLAG_SECOND = 2;
  localparam int FLAG_TIME_EVENT = 3;
  localparam int FLAG_CALENDAR_EVENT = 4;
  localparam int TIME_CHOICE_LSB = 0;
  localparam int CAL_CHOICE_LSB = 4;

  // Reset values
  localparam logic [7:0] CENTURY_RST = 8'h00;
  localparam logic [7:0] ALARM_RST = 8'h00;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [4:0] IRQ_ENABLES_RST = 5'h00;
  localparam logic [1:0] CHOICE_RST = 2'h0;

  // BCD values with meaning
  localparam logic [7:0] CENTURY_LOW = 8'h19;
  localparam logic [7:0] CENTURY_HIGH = 8'h20;
  localparam logic [7:0] NOON_HOUR = 8'h12;
  localparam logic [7:0] MIDNIGHT_HOUR = 8'h00;
  localparam logic [7:0] SUNDAY_DAY = 8'h07;
  localparam logic [7:0] FIRST_DATE = 8'h01;
  localparam logic [7:0] JANUARY_MONTH = 8'h01;

  typedef enum logic [1:0] {
    TEV_MINUTE,
    TEV_HOUR,
    TEV_MIDNIGHT,
    TEV_NOON
  } rta_time_choice_e;

  typedef enum logic [1:0] {
    CEV_WEEK,
    CEV_MONTH,
    CEV_YEAR,
    CEV_RESERVED
  } rta_cal_choice_e;

endpackage : rta_pkg

// ===== hw/rta_alarm_match.sv
// Alarm comparator: enabled alarm fields against the current BCD time.
// Assumes alarm registers and time values come from the same clock domain.
`timescale 1ns/1ps
module rta_alarm_match
  import rta_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] secondAlarm,
  input wire logic [7:0] minuteAlarm,
  input wire logic [7:0] hourAlarm,
  input wire logic [7:0] dateAlarm,
  input wire logic [7:0] monthAlarm,
  input wire logic [7:0] curSec,
  input wire logic [7:0] curMin,
  input wire logic [7:0] curHour,
  input wire logic [7:0] curDate,
  input wire logic [7:0] curMonth,
  output logic allMatch
);

  logic [7:0] alarmVal [NUM_ALARMS];
  logic [7:0] curVal [NUM_ALARMS];
  logic [NUM_ALARMS-1:0] fieldEnable;
  logic [NUM_ALARMS-1:0] fieldOk;

  assign alarmVal[ALM_SEC] = secondAlarm;
  assign alarmVal[ALM_MIN] = minuteAlarm;
  assign alarmVal[ALM_HOUR] = hourAlarm;
  assign alarmVal[ALM_DATE] = dateAlarm;
  assign alarmVal[ALM_MONTH] = monthAlarm;
  assign curVal[ALM_SEC] = curSec;
  assign curVal[ALM_MIN] = curMin;
  assign curVal[ALM_HOUR] = curHour;
  assign curVal[ALM_DATE] = curDate;
  assign curVal[ALM_MONTH] = curMonth;

  genvar i;
  generate
    for (i = 0; i < NUM_ALARMS; i++) begin : g_field
      assign fieldEnable[i] = alarmVal[i][ALARM_ENABLE_BIT];
      // A disabled field never blocks the match
      assign fieldOk[i] = !fieldEnable[i] ||
        (alarmVal[i][ALARM_ENABLE_BIT-1:0] == curVal[i][ALARM_ENABLE_BIT-1:0]);
    end
  endgenerate

  // With every field disabled the alarm stays silent
  assign allMatch = (|fieldEnable) && (&fieldOk);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_sec_mismatch: assert property (
    (secondAlarm[ALARM_ENABLE_BIT] && (secondAlarm[6:0] != curSec[6:0])) |-> !allMatch)
    else $error("alarm match despite enabled second mismatch");

  chk_all_disabled: assert property (
    (!secondAlarm[7] && !minuteAlarm[7] && !hourAlarm[7] && !dateAlarm[7]
      && !monthAlarm[7]) |-> !allMatch)
    else $error("alarm match with all fields disabled");

endmodule : rta_alarm_match

// ===== hw/rta_event_detect.sv
// Periodic event detector: watches the BCD time values for changes and
// raises one-cycle second, time and calendar events per the chosen kind.
// Assumes the time values come from counters on the same clock.
`timescale 1ns/1ps
module rta_event_detect
  import rta_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] curSec,
  input wire logic [7:0] curMin,
  input wire logic [7:0] curHour,
  input wire logic [7:0] curDay,
  input wire logic [7:0] curDate,
  input wire logic [7:0] curMonth,
  input wire rta_time_choice_e timeEventChoice,
  input wire rta_cal_choice_e calendarEventChoice,
  output logic secondEvent,
  output logic timeEvent,
  output logic calendarEvent
);

  logic [7:0] curVal [NUM_TIME_FIELDS];
  logic [7:0] prevVal_q [NUM_TIME_FIELDS];
  logic [NUM_TIME_FIELDS-1:0] changed;
  logic primed_q;

  assign curVal[0] = curSec;
  assign curVal[1] = curMin;
  assign curVal[2] = curHour;
  assign curVal[3] = curDay;
  assign curVal[4] = curDate;
  assign curVal[5] = curMonth;

  // First cycle after reset only loads history, so no false event
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      primed_q <= 1'b0;
    end else begin
      primed_q <= 1'b1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < NUM_TIME_FIELDS; i++) begin : g_hist
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          prevVal_q[i] <= 8'h00;
        end else begin
          prevVal_q[i] <= curVal[i];
        end
      end
      assign changed[i] = primed_q && (curVal[i] != prevVal_q[i]);
    end
  endgenerate

  assign secondEvent = changed[0];

  always_comb begin
    unique case (timeEventChoice)
      TEV_MINUTE: timeEvent = changed[1];
      TEV_HOUR: timeEvent = changed[2];
      TEV_MIDNIGHT: timeEvent = changed[2] && (curHour == MIDNIGHT_HOUR);
      TEV_NOON: timeEvent = changed[2] && (curHour == NOON_HOUR);
    endcase
  end

  always_comb begin
    unique case (calendarEventChoice)
      CEV_WEEK: calendarEvent = changed[3] && (curDay == SUNDAY_DAY);
      CEV_MONTH: calendarEvent = changed[4] && (curDate == FIRST_DATE);
      CEV_YEAR: calendarEvent = changed[5] && (curMonth == JANUARY_MONTH);
      CEV_RESERVED: calendarEvent = 1'b0;
    endcase
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_noon_event: assert property (
    (timeEventChoice == TEV_NOON && timeEvent) |-> (curHour == NOON_HOUR && $changed(curHour)))
    else $error("noon event without hour turning to noon");

  chk_reserved_cal: assert property (
    (calendarEventChoice == CEV_RESERVED) |-> !calendarEvent)
    else $error("calendar event under reserved choice");

endmodule : rta_event_detect

// ===== tb/rta_host_model.sv
// Host core model: single-byte register reads and writes on the peripheral bus.
// Assumes the block takes a strobe at a rising edge and answers a read a cycle later.
`timescale 1ns/1ps
module rta_host_model
  import rta_pkg::*;
(
  input wire logic sys_clk,
  output logic [7:0] busAddr,
  output logic busWrEn,
  output logic busRdEn,
  output logic [DATA_W-1:0] busWrData,
  input wire logic [DATA_W-1:0] busRdData
);
  initial begin
    busAddr = 8'h00;
    busWrEn = 1'b0;
    busRdEn = 1'b0;
    busWrData = 8'h00;
  end

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    busAddr <= addr;
    busWrData <= data;
    busWrEn <= 1'b1;
    @(posedge sys_clk);
    busWrEn <= 1'b0;
    // Stale data must not look valid once the strobe is gone
    busWrData <= ~data;
  endtask : wr

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge sys_clk);
    busAddr <= addr;
    busRdEn <= 1'b1;
    @(posedge sys_clk);
    busRdEn <= 1'b0;
    #1;
    data = busRdData;
  endtask : rd
endmodule : rta_host_model

// ===== tb/testbench.sv
// Self-checking bench for the alarm and event-flag block.
// Assumes the host model owns the register bus; the bench drives the time values.
`timescale 1ns/1ps
module testbench
  import rta_pkg::*;
;
  logic sys_clk;
  logic reset;
  logic updateGranted;
  logic [7:0] curT [6];
  logic [7:0] busAddr;
  logic busWrEn;
  logic busRdEn;
  logic [7:0] busWrData;
  logic [7:0] busRdData;
  logic irq;
  logic [7:0] rdv;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;

  rta_alarm_flags dut (.sys_clk(sys_clk), .reset(reset), .busAddr(busAddr),
    .busWrEn(busWrEn), .busRdEn(busRdEn), .busWrData(busWrData), .busRdData(busRdData),
    .curSec(curT[0]), .curMin(curT[1]), .curHour(curT[2]), .curDay(curT[3]),
    .curDate(curT[4]), .curMonth(curT[5]), .updateGranted(updateGranted), .irq(irq));
  rta_host_model host (.sys_clk(sys_clk), .busAddr(busAddr), .busWrEn(busWrEn),
    .busRdEn(busRdEn), .busWrData(busWrData), .busRdData(busRdData));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  // Whole run needs a few hundred cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      summarize();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chkBit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chkBit

  task automatic readChk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
    host.rd(a, rdv);
    chk8(rdv & m, exp, "register read");
  endtask : readChk

  task automatic setT(input int i, input logic [7:0] v);
    @(posedge sys_clk);
    curT[i] <= v;
    repeat (2) @(posedge sys_clk);
  endtask : setT

  task automatic testReset();
    logic [7:0] offs [11] = '{OFF_CENTURY, OFF_SEC_ALARM, OFF_MIN_ALARM, OFF_HOUR_ALARM,
      OFF_MONTH_ALARM, OFF_DATE_ALARM, OFF_EVENT_FLAGS, OFF_EVENT_FLAG_CLEAR,
      OFF_INTERRUPT_ENABLES, OFF_EVENT_CHOICE, 8'h30};
    foreach (offs[i]) readChk(offs[i], 8'h00, 8'hff);
    host.wr(OFF_EVENT_FLAGS, 8'hff);
    readChk(OFF_EVENT_FLAGS, 8'h00, 8'hff);
    chkBit(irq, 1'b0, "irq after reset");
  endtask : testReset

  task automatic testCentury();
    logic [7:0] wv [4] = '{8'h19, 8'h21, 8'h20, 8'h00};
    logic [7:0] ev [4] = '{8'h19, 8'h19, 8'h20, 8'h20};
    foreach (wv[i]) begin
      host.wr(OFF_CENTURY, wv[i]);
      readChk(OFF_CENTURY, ev[i], 8'hff);
    end
  endtask : testCentury

  task automatic testAlarms();
    logic [7:0] offs [5] = '{OFF_SEC_ALARM, OFF_MIN_ALARM, OFF_HOUR_ALARM, OFF_DATE_ALARM,
      OFF_MONTH_ALARM};
    int ci [5] = '{0, 1, 2, 4, 5};
    logic [7:0] av [5] = '{8'h45, 8'h30, 8'h21, 8'h28, 8'h11};
    foreach (offs[k]) begin
      setT(ci[k], av[k]);
      host.wr(offs[k], av[k]);
      host.wr(OFF_EVENT_FLAG_CLEAR, 8'h1f);
      readChk(OFF_EVENT_FLAGS, 8'h00, 8'h02);
      host.wr(offs[k], av[k] | 8'h80);
      readChk(OFF_EVENT_FLAGS, 8'h02, 8'h02);
      readChk(offs[k], av[k] | 8'h80, 8'hff);
      host.wr(offs[k], 8'h00);
    end
    host.wr(OFF_SEC_ALARM, 8'hc5);
    host.wr(OFF_MIN_ALARM, 8'hb1);
    host.wr(OFF_EVENT_FLAG_CLEAR, 8'h02);
    readChk(OFF_EVENT_FLAGS, 8'h00, 8'h02);
    setT(1, 8'h31);
    readChk(OFF_EVENT_FLAGS, 8'h02, 8'h02);
    host.wr(OFF_EVENT_FLAG_CLEAR, 8'h02);
    setT(0, 8'h44);
    readChk(OFF_EVENT_FLAGS, 8'h00, 8'h02);
    setT(0, 8'h45);
    readChk(OFF_EVENT_FLAGS, 8'h02, 8'h02);
    host.wr(OFF_SEC_ALARM, 8'h00);
    host.wr(OFF_MIN_ALARM, 8'h00);
  endtask : testAlarms

  task automatic testEvents();
    logic [7:0] ch [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h00, 8'h10, 8'h20, 8'h30};
    logic [7:0] m [8] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h10, 8'h10, 8'h10, 8'h10};
    int ni [8] = '{2, 1, 2, 2, 3, 4, 5, 3};
    logic [7:0] nv [8] = '{8'h05, 8'h08, 8'h12, 8'h13, 8'h03, 8'h15, 8'h06, 8'h01};
    int ti [8] = '{1, 2, 2, 2, 3, 4, 5, 3};
    logic [7:0] tv [8] = '{8'h07, 8'h06, 8'h00, 8'h12, 8'h07, 8'h01, 8'h01, 8'h07};
    logic [7:0] ex [8] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h10, 8'h10, 8'h10, 8'h00};
    foreach (ch[i]) begin
      host.wr(OFF_EVENT_CHOICE, ch[i]);
      readChk(OFF_EVENT_CHOICE, ch[i], 8'hff);
      host.wr(OFF_EVENT_FLAG_CLEAR, 8'h1f);
      setT(ni[i], nv[i]);
      readChk(OFF_EVENT_FLAGS, 8'h00, m[i]);
      setT(ti[i], tv[i]);
      readChk(OFF_EVENT_FLAGS, ex[i], m[i]);
      readChk(OFF_EVENT_FLAGS, ex[i], m[i]);
    end
  endtask : testEvents

  task automatic testIrq();
    host.wr(OFF_EVENT_FLAG_CLEAR, 8'h1f);
    @(posedge sys_clk);
    updateGranted <= 1'b1;
    @(posedge sys_clk);
    updateGranted <= 1'b0;
    setT(0, 8'h46);
    readChk(OFF_EVENT_FLAGS, 8'h05, 8'h1f);
    for (int b = 0; b < 5; b++) begin
      host.wr(OFF_INTERRUPT_ENABLES, 8'h01 << b);
      repeat (2) @(posedge sys_clk);
      chkBit(irq, (b == 0 || b == 2), "irq per enable");
    end
    host.wr(OFF_INTERRUPT_ENABLES, 8'hff);
    readChk(OFF_INTERRUPT_ENABLES, 8'h1f, 8'hff);
    host.wr(OFF_INTERRUPT_ENABLES, 8'h05);
    host.wr(OFF_EVENT_FLAG_CLEAR, 8'h04);
    repeat (2) @(posedge sys_clk);
    chkBit(irq, 1'b1, "irq held by other flag");
    host.wr(OFF_EVENT_FLAG_CLEAR, 8'h00);
    readChk(OFF_EVENT_FLAGS, 8'h01, 8'h1f);
    host.wr(OFF_EVENT_FLAG_CLEAR, 8'h01);
    repeat (2) @(posedge sys_clk);
    chkBit(irq, 1'b0, "irq after last clear");
  endtask : testIrq

  task automatic testSetWins();
    setT(0, 8'h50);
    fork
      host.wr(OFF_EVENT_FLAG_CLEAR, 8'h04);
      begin
        @(posedge sys_clk);
        curT[0] <= 8'h51;
      end
    join
    readChk(OFF_EVENT_FLAGS, 8'h04, 8'h04);
    host.wr(OFF_EVENT_FLAG_CLEAR, 8'h04);
    readChk(OFF_EVENT_FLAGS, 8'h00, 8'h04);
  endtask : testSetWins

  initial begin
    reset = 1'b1;
    updateGranted = 1'b0;
    foreach (curT[i]) curT[i] = 8'h00;
    repeat (6) @(posedge sys_clk);
    #1;
    chkBit(irq, 1'b0, "irq in reset");
    chk8(busRdData, 8'h00, "read data in reset");
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    testReset();
    testCentury();
    testAlarms();
    testEvents();
    testIrq();
    testSetWins();
    summarize();
  end
endmodule : testbench
